// ---- sleep_wake_manager.sv ----
// sleep and wake manager: antenna select, straps, low-power and check-in retries
// Operation
// - tx: A low B high; rx: reverse
// - low strap at boot: capture pins, sleep
// - sleeping: radio hibernates, core stops
// - byte 8 is the watch mask
// - watched input change wakes, sends C1
// - bytes 4 and 5 set sleep length
// - timer expiry wakes, broadcasts C2
// - no reply in awake window: sleep
// - command A4 sends device back to sleep
// - byte 6 half-seconds: resend each 500 ms
// - reserved strap low at boot: reserved mode
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module sleep_wake_manager
  import sleep_wake_pkg::*;
#(
  parameter int HALF_SEC = HALF_SEC_CYC,
  parameter int SLEEP_UNIT = SLEEP_UNIT_CYC
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // register bus
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // strap and watched pins
  input wire logic LOW_POWER_STRAP,
  input wire logic RESERVED_MODE_STRAP,
  input wire logic WATCH_INPUT_A6,
  input wire logic WATCH_INPUT_B6,
  input wire logic WATCH_INPUT_A2,
  input wire logic WATCH_INPUT_A1,
  input wire logic WATCH_INPUT_B3,
  input wire logic WATCH_INPUT_B2,
  input wire logic WATCH_INPUT_B1,
  input wire logic WATCH_INPUT_B0,
  // commands received from the radio
  input wire logic RX_CMD_VALID,
  input wire logic [7:0] RX_CMD,
  // antenna, power and check-in outputs
  output logic ANTENNA_SELECT_A,
  output logic ANTENNA_SELECT_B,
  output logic RADIO_HIBERNATE,
  output logic CORE_STOP,
  output logic RESERVED_MODE,
  output logic PKT_SEND,
  output logic [7:0] PKT_CMD,
  output logic [7:0] PKT_PIN_STATE,
  output logic [7:0] PKT_PIN_CHANGED,
  output logic IRQ
);

  typedef struct packed {
    state_t st;
    logic [1:0] boot_cnt;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] base;
    logic [7:0] chg;
    logic rsv;
    logic ctrl_tx;
    logic [31:0] cfg;
    logic [15:0] sleep;
    logic [EV_W-1:0] ist;
    logic [EV_W-1:0] imask;
    logic [30:0] tick;
    logic [15:0] units;
    logic [7:0] tries;
    logic awready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic ant_a;
    logic ant_b;
    logic hib;
    logic pkt_send;
    logic [7:0] pkt_cmd;
    logic irq;
  } regs_t;

  regs_t q;
  regs_t d;

  // byte-lane merge of a register write
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic [7:0] mask;
  logic [7:0] awake_eff;
  logic [15:0] sleep_eff;
  logic [7:0] pin_hit;
  logic unit_done;
  logic timer_done;
  logic half_done;
  logic last_try;
  logic sleep_cmd;
  logic boot_done;

  // wake conditions; zero lengths act as one so the block never stalls
  always_comb begin
    mask = q.cfg[CFG_MASK_LSB +: 8];
    awake_eff = (q.cfg[CFG_AWAKE_LSB +: 8] == 8'h00) ? 8'h01 : q.cfg[CFG_AWAKE_LSB +: 8];
    sleep_eff = (q.sleep == 16'h0000) ? 16'h0001 : q.sleep;
    pin_hit = (q.pin_s2 ^ q.base) & mask & q.cfg[CFG_INEN_LSB +: 8];
    unit_done = q.tick == 31'(SLEEP_UNIT - 1);
    timer_done = unit_done && ({1'b0, q.units} + 17'h00001 >= {1'b0, sleep_eff});
    half_done = q.tick == 31'(HALF_SEC - 1);
    last_try = {1'b0, q.tries} + 9'h001 >= {1'b0, awake_eff};
    sleep_cmd = RX_CMD_VALID && RX_CMD == CMD_SLEEP;
    boot_done = q.boot_cnt == BOOT_SYNC_CYC;
  end

  // next state of everything
  always_comb begin
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic tx;
    logic [31:0] slw;
    ev = '0;
    clr = '0;
    tx = 1'b0;
    slw = '0;
    d = q;
    // pin synchronisers, first stage read only by the second
    d.strap_s1 = {RESERVED_MODE_STRAP, LOW_POWER_STRAP};
    d.strap_s2 = q.strap_s1;
    d.pin_s1 = {WATCH_INPUT_A6, WATCH_INPUT_B6, WATCH_INPUT_A2, WATCH_INPUT_A1,
                WATCH_INPUT_B3, WATCH_INPUT_B2, WATCH_INPUT_B1, WATCH_INPUT_B0};
    d.pin_s2 = q.pin_s1;
    d.tick = q.tick + 31'h00000001;
    d.pkt_send = 1'b0;
    // baseline follows the pins whenever no watch is active
    if (q.st != ST_SLEEP && q.st != ST_IDLE) begin
      d.base = q.pin_s2;
    end
    case (q.st)
      ST_BOOT: begin
        if (!boot_done) begin
          d.boot_cnt = q.boot_cnt + 2'h1;
        end else begin
          d.rsv = !q.strap_s2[1];
          d.base = q.pin_s2;
          d.st = q.strap_s2[0] ? ST_IDLE : ST_SLEEP;
        end
      end
      ST_IDLE, ST_SLEEP: begin
        // a pin change beats a timer expiry in the same cycle
        if (|pin_hit) begin
          d.chg = pin_hit;
          d.base = q.pin_s2;
          d.pkt_cmd = CMD_PIN_WAKE;
          ev[EV_PIN] = 1'b1;
          d.st = ST_SEND;
        end else if (q.st == ST_SLEEP) begin
          if (unit_done) begin
            d.tick = '0;
            d.units = q.units + 16'h0001;
          end
          if (timer_done) begin
            d.chg = 8'h00;
            d.pkt_cmd = CMD_TIMER_WAKE;
            ev[EV_TIMER] = 1'b1;
            d.st = ST_SEND;
          end
        end else if (sleep_cmd) begin
          ev[EV_SLEEPCMD] = 1'b1;
          d.st = ST_SLEEP;
        end
      end
      ST_SEND: begin
        d.pkt_send = 1'b1;
        d.st = ST_WAIT;
      end
      ST_WAIT: begin
        // any command from the controller counts as the reply
        if (sleep_cmd) begin
          ev[EV_SLEEPCMD] = 1'b1;
          d.st = ST_SLEEP;
        end else if (RX_CMD_VALID) begin
          d.st = ST_IDLE;
        end else if (half_done) begin
          d.tries = q.tries + 8'h01;
          if (last_try) begin
            ev[EV_GIVEUP] = 1'b1;
            d.st = ST_SLEEP;
          end else begin
            d.st = ST_SEND;
          end
        end
      end
      default: begin
        d.st = ST_BOOT;
      end
    endcase
    // register writes, taken one cycle after ready is raised
    d.awready = 1'b0;
    if (!q.awready && !q.bvalid && AWVALID && WVALID) begin
      d.awready = 1'b1;
    end
    if (q.bvalid && BREADY) begin
      d.bvalid = 1'b0;
    end
    if (q.awready) begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (AWADDR)
        OFS_CTRL: begin
          if (WSTRB[0]) begin
            d.ctrl_tx = WDATA[CTRL_TX];
            if (WDATA[CTRL_SLEEP] && (q.st == ST_IDLE || q.st == ST_WAIT)) begin
              d.st = ST_SLEEP;
            end
          end
        end
        OFS_CFG: d.cfg = wmerge(q.cfg, WDATA, WSTRB);
        OFS_SLEEP: begin
          // upper half of the word is not stored
          slw = wmerge({16'h0000, q.sleep}, WDATA, WSTRB);
          d.sleep = slw[15:0];
        end
        OFS_STATUS: d.bresp = RESP_OKAY;
        OFS_INT_STAT: clr = WSTRB[0] ? WDATA[EV_W-1:0] : '0;
        OFS_INT_MASK: d.imask = WSTRB[0] ? WDATA[EV_W-1:0] : q.imask;
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    // register reads
    d.arready = 1'b0;
    if (!q.arready && !q.rvalid && ARVALID) begin
      d.arready = 1'b1;
    end
    if (q.rvalid && RREADY) begin
      d.rvalid = 1'b0;
    end
    if (q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      case (ARADDR)
        OFS_CTRL: d.rdata = {31'h00000000, q.ctrl_tx};
        OFS_CFG: d.rdata = q.cfg;
        OFS_SLEEP: d.rdata = {16'h0000, q.sleep};
        OFS_STATUS: d.rdata = {8'h00, q.tries, q.pin_s2, 1'b0, q.ant_b, q.ant_a, q.strap_s2[0], q.rsv, q.st};
        OFS_INT_STAT: d.rdata = {28'h0000000, q.ist};
        OFS_INT_MASK: d.rdata = {28'h0000000, q.imask};
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    // sticky events: a new event wins over a clear in the same cycle
    d.ist = (q.ist & ~clr) | ev;
    d.irq = |(d.ist & d.imask);
    if (d.st != q.st) begin
      d.tick = '0;
      d.units = '0;
    end
    if (d.st == ST_SLEEP || d.st == ST_IDLE) begin
      d.tries = 8'h00;
    end
    // transmit while sending a check-in or when software asks for it
    tx = d.pkt_send || d.st == ST_SEND || d.ctrl_tx;
    d.ant_a = !tx;
    d.ant_b = tx;
    d.hib = d.st == ST_SLEEP;
  end

  // single register of all state
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      q <= '{st: ST_BOOT, cfg: CFG_RST, sleep: SLEEP_RST, ant_a: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign AWREADY = q.awready;
  assign WREADY = q.awready;
  assign BVALID = q.bvalid;
  assign BRESP = q.bresp;
  assign ARREADY = q.arready;
  assign RVALID = q.rvalid;
  assign RRESP = q.rresp;
  assign RDATA = q.rdata;
  assign ANTENNA_SELECT_A = q.ant_a;
  assign ANTENNA_SELECT_B = q.ant_b;
  assign RADIO_HIBERNATE = q.hib;
  assign CORE_STOP = q.hib;
  assign RESERVED_MODE = q.rsv;
  assign PKT_SEND = q.pkt_send;
  assign PKT_CMD = q.pkt_cmd;
  assign PKT_PIN_STATE = q.base;
  assign PKT_PIN_CHANGED = q.chg;
  assign IRQ = q.irq;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  chk_antenna_tx_rx: assert property (PKT_SEND |-> !ANTENNA_SELECT_A && ANTENNA_SELECT_B
    ##1 (ANTENNA_SELECT_A != ANTENNA_SELECT_B)) else $error("antenna selects wrong");
  chk_boot_low_power: assert property (q.st == ST_BOOT && boot_done && !q.strap_s2[0]
    |=> q.st == ST_SLEEP && q.base == $past(q.pin_s2)) else $error("low power strap ignored");
  chk_sleep_power_down: assert property (q.st == ST_SLEEP |-> RADIO_HIBERNATE && CORE_STOP)
    else $error("sleep without hibernate");
  chk_pin_wake_c1: assert property (q.st == ST_SLEEP && |pin_hit
    |=> ##1 PKT_SEND && PKT_CMD == CMD_PIN_WAKE) else $error("pin wake check-in missing");
  chk_timer_wake_c2: assert property (q.st == ST_SLEEP && timer_done && pin_hit == 8'h00
    |=> ##1 PKT_SEND && PKT_CMD == CMD_TIMER_WAKE) else $error("timer check-in missing");
  chk_sleep_units: assert property (q.st == ST_SLEEP |-> q.units < sleep_eff)
    else $error("sleep timer overran");
  chk_give_up: assert property (q.st == ST_WAIT && half_done && last_try && !RX_CMD_VALID
    |=> q.st == ST_SLEEP && (IRQ || !q.imask[EV_GIVEUP])) else $error("no return to sleep");
  chk_sleep_command: assert property (sleep_cmd && (q.st == ST_WAIT || q.st == ST_IDLE)
    |=> q.st == ST_SLEEP ##1 RADIO_HIBERNATE) else $error("sleep command ignored");
  chk_retry_bound: assert property (q.st == ST_WAIT |-> q.tries < awake_eff)
    else $error("too many retries");
  chk_reserved_mode: assert property (q.st == ST_BOOT && boot_done
    |=> RESERVED_MODE == !$past(q.strap_s2[1])) else $error("reserved strap missed");

endmodule
`default_nettype wire

// ---- sleep_wake_pkg.sv ----
// package: constants, register map and types of the sleep and wake manager
package sleep_wake_pkg;
  // clock and times
  localparam int CLK_MHZ = 250;
  localparam int HALF_SEC_MS = 500;
  localparam int SLEEP_UNIT_S = 5;
  localparam int HALF_SEC_CYC = HALF_SEC_MS * CLK_MHZ * 1000;
  localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_S * CLK_MHZ * 1000000;
  // cycles after reset until the strap synchronisers hold settled values
  localparam logic [1:0] BOOT_SYNC_CYC = 2'h3;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_SLEEP = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  // control bits
  localparam int CTRL_TX = 0;
  localparam int CTRL_SLEEP = 1;
  // config fields: watch mask, awake half-seconds, input enables
  localparam int CFG_MASK_LSB = 0;
  localparam int CFG_AWAKE_LSB = 8;
  localparam int CFG_INEN_LSB = 16;
  localparam logic [31:0] CFG_RST = 32'h00FF0200;
  localparam logic [15:0] SLEEP_RST = 16'h0001;
  // event bits of the interrupt status
  localparam int EV_PIN = 0;
  localparam int EV_TIMER = 1;
  localparam int EV_GIVEUP = 2;
  localparam int EV_SLEEPCMD = 3;
  localparam int EV_W = 4;
  // radio commands
  localparam logic [7:0] CMD_PIN_WAKE = 8'hC1;
  localparam logic [7:0] CMD_TIMER_WAKE = 8'hC2;
  localparam logic [7:0] CMD_SLEEP = 8'hA4;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_SLEEP, ST_SEND, ST_WAIT} state_t;
endpackage

// ---- sleep_wake_ctrl_model.sv ----
// remote controller model: answers each check-in once, or stays silent
`timescale 1ns/10ps
`default_nettype none
module sleep_wake_ctrl_model
  import sleep_wake_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // check-in seen and reply control
  input wire logic pkt_send,
  input wire logic reply_en,
  // reply towards the device
  output logic rx_cmd_valid,
  output logic [7:0] rx_cmd
);
  logic [3:0] dly_q;
  // one reply per check-in, a few cycles late like a real link
  always_ff @(posedge clk) begin
    if (srst) begin
      dly_q <= 4'h0;
      rx_cmd_valid <= 1'b0;
      rx_cmd <= 8'h00;
    end else begin
      if (pkt_send && reply_en) dly_q <= 4'h5;
      else if (dly_q != 4'h0) dly_q <= dly_q - 4'h1;
      if (dly_q == 4'h1) begin
        rx_cmd_valid <= 1'b1;
        rx_cmd <= CMD_SLEEP;
      end else begin
        rx_cmd_valid <= 1'b0;
        rx_cmd <= ~rx_cmd; // code inverts each cycle between replies, so the last reply code recurs every other cycle
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// testbench of the sleep and wake manager
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sleep_wake_pkg::*;
  typedef struct {int pin; logic [7:0] mask; logic [7:0] cmd; logic [7:0] chg;} row_t;
  logic clk = 1'b0, srst = 1'b1, lps = 1'b0, rms = 1'b0, reply_en = 1'b1;
  logic [7:0] pins = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ant_a, ant_b, hib, stop, rsv, psend, irq, rxv;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata;
  logic [7:0] pcmd, pstate, pchg, rxc, got_cmd, got_chg;
  logic got_a, got_b;
  int num_errors = 0, checks = 0, npkt = 0, cyc = 0, n0;
  row_t rows[9];
  // short counts keep the run brief
  sleep_wake_manager #(.HALF_SEC(20), .SLEEP_UNIT(50)) u_dut (.CORE_CLK(clk), .SRST(srst),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .LOW_POWER_STRAP(lps), .RESERVED_MODE_STRAP(rms),
    .WATCH_INPUT_A6(pins[7]), .WATCH_INPUT_B6(pins[6]), .WATCH_INPUT_A2(pins[5]),
    .WATCH_INPUT_A1(pins[4]), .WATCH_INPUT_B3(pins[3]), .WATCH_INPUT_B2(pins[2]),
    .WATCH_INPUT_B1(pins[1]), .WATCH_INPUT_B0(pins[0]), .RX_CMD_VALID(rxv), .RX_CMD(rxc),
    .ANTENNA_SELECT_A(ant_a), .ANTENNA_SELECT_B(ant_b), .RADIO_HIBERNATE(hib), .CORE_STOP(stop),
    .RESERVED_MODE(rsv), .PKT_SEND(psend), .PKT_CMD(pcmd), .PKT_PIN_STATE(pstate),
    .PKT_PIN_CHANGED(pchg), .IRQ(irq));
  sleep_wake_ctrl_model u_ctrl (.clk(clk), .srst(srst), .pkt_send(psend), .reply_en(reply_en),
    .rx_cmd_valid(rxv), .rx_cmd(rxc));
  always #2 clk = ~clk;
  // capture each check-in in its pulse cycle; watchdog cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (psend === 1'b1) begin
      npkt <= npkt + 1;
      got_cmd <= pcmd;
      got_chg <= pchg;
      got_a <= ant_a;
      got_b <= ant_b;
    end
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge clk);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_hib(input logic v);
    int k;
    for (k = 0; k < 300 && hib !== v; k++) @(posedge clk);
    #1 cmp("RADIO_HIBERNATE", {31'h0, v}, {31'h0, hib});
  endtask
  task automatic end_sim();
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 8; i++) rows[i] = '{i, 8'h01 << i, CMD_PIN_WAKE, 8'h01 << i};
    rows[8] = '{0, 8'h02, CMD_TIMER_WAKE, 8'h00};
    // reset values, then low strap sends it straight to sleep
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1 cmp("ant A/B rx", 32'h2, {30'h0, ant_a, ant_b});
    wait_hib(1'b1);
    cmp("CORE_STOP", 32'h1, {31'h0, stop});
    cmp("RESERVED_MODE", 32'h1, {31'h0, rsv});
    @(posedge clk);
    srst <= 1'b1;
    rms <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    wait_hib(1'b1);
    cmp("RESERVED_MODE off", 32'h0, {31'h0, rsv});
    // each watched pin alone, then an unwatched pin loses to the timer
    foreach (rows[i]) begin
      n0 = npkt;
      axi_wr(OFS_CFG, {8'h00, 8'hFF, 8'h01, rows[i].mask});
      @(posedge clk);
      pins[rows[i].pin] <= ~pins[rows[i].pin];
      for (int k = 0; k < 300 && npkt == n0; k++) @(posedge clk);
      #1 cmp("PKT_CMD", {24'h0, rows[i].cmd}, {24'h0, got_cmd});
      cmp("PKT_PIN_CHANGED", {24'h0, rows[i].chg}, {24'h0, got_chg});
      cmp("ant A/B tx", 32'h1, {30'h0, got_a, got_b});
      wait_hib(1'b1);
    end
    cmp("PKT_PIN_STATE", {24'h0, pins}, {24'h0, pstate});
    // silent controller: one send plus one retry, then give up
    reply_en <= 1'b0;
    axi_wr(OFS_INT_MASK, 32'h00000004);
    axi_wr(OFS_CFG, 32'h00FF0200);
    n0 = npkt;
    wait_hib(1'b0);
    wait_hib(1'b1);
    cmp("packet count", 32'h2, npkt - n0);
    cmp("IRQ", 32'h1, {31'h0, irq});
    axi_rd(OFS_INT_STAT);
    cmp("INT_STAT gave up", 32'h4, rd & 32'h4);
    axi_wr(OFS_INT_STAT, 32'h00000004);
    repeat (2) @(posedge clk);
    #1 cmp("IRQ cleared", 32'h0, {31'h0, irq});
    // software forces the transmit antenna, then releases it
    axi_wr(OFS_CTRL, 32'h00000001);
    #1 cmp("ant A/B forced", 32'h1, {30'h0, ant_a, ant_b});
    cmp("CTRL BRESP", {30'h0, RESP_OKAY}, {30'h0, rs});
    axi_wr(OFS_CTRL, 32'h00000000);
    #1 cmp("ant A/B released", 32'h2, {30'h0, ant_a, ant_b});
    axi_rd(8'h40);
    cmp("unmapped RRESP", {30'h0, RESP_SLVERR}, {30'h0, rs});
    cmp("unmapped RDATA", 32'h0, rd);
    end_sim();
  end
endmodule
`default_nettype wire
